// ---- core/apd_select_pkg.sv ----
package apd_select_pkg;

	// ----------------------------------------------------------------
	// register indices and byte addresses (byte address = index * 4)
	// ----------------------------------------------------------------
	localparam logic [7:0]  IDX_PD_ENABLE  = 8'h40;
	localparam logic [7:0]  IDX_CONV_SEL1  = 8'h45;
	localparam logic [7:0]  IDX_PIN_SEL0   = 8'h46;
	localparam logic [7:0]  IDX_PIN_SEL1   = 8'h47;
	localparam logic [7:0]  IDX_IRQ_STATUS = 8'h50;
	localparam logic [7:0]  IDX_IRQ_CLEAR  = 8'h51;
	localparam logic [7:0]  IDX_IRQ_ENABLE = 8'h52;
	localparam logic [11:0] ADDR_PD_ENABLE  = {2'b00, IDX_PD_ENABLE, 2'b00};
	localparam logic [11:0] ADDR_CONV_SEL1  = {2'b00, IDX_CONV_SEL1, 2'b00};
	localparam logic [11:0] ADDR_PIN_SEL0   = {2'b00, IDX_PIN_SEL0, 2'b00};
	localparam logic [11:0] ADDR_PIN_SEL1   = {2'b00, IDX_PIN_SEL1, 2'b00};
	localparam logic [11:0] ADDR_IRQ_STATUS = {2'b00, IDX_IRQ_STATUS, 2'b00};
	localparam logic [11:0] ADDR_IRQ_CLEAR  = {2'b00, IDX_IRQ_CLEAR, 2'b00};
	localparam logic [11:0] ADDR_IRQ_ENABLE = {2'b00, IDX_IRQ_ENABLE, 2'b00};

	// ----------------------------------------------------------------
	// reset values and writable masks
	// ----------------------------------------------------------------
	localparam logic [15:0] RST_CONV_SEL1 = 16'h1833;
	localparam logic [15:0] RST_PIN_SEL0  = 16'h0000;
	localparam logic [15:0] RST_PIN_SEL1  = 16'h1833;
	localparam logic [15:0] MASK_SEL0     = 16'h0133;
	localparam logic [15:0] MASK_SEL1     = 16'h3833;
	localparam logic [3:0]  RST_CONV_EN   = 4'hF;
	localparam logic [1:0]  RST_PIN_MODE  = 2'h2;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int EXT_BIT   = 13;
	localparam int REF_BIT   = 12;
	localparam int THERM_BIT = 11;
	localparam int NEGB_BIT  = 5;
	localparam int NEGA_BIT  = 4;
	localparam int POSB_BIT  = 1;
	localparam int POSA_BIT  = 0;
	localparam int TEMP_BIT  = 8;
	localparam int MON1_BIT  = 5;
	localparam int MON0_BIT  = 4;
	localparam int CUR1_BIT  = 1;
	localparam int CUR0_BIT  = 0;
	localparam int EN_LSB    = 0;
	localparam int MODE_LSB  = 8;
	localparam int CLAMP_BIT = 12;
	localparam int LIVE_LSB  = 4;
	localparam int ALARM_W   = 12;

	// alarm levels coming from the monitor blocks
	typedef struct packed {
		logic ext_alarm;
		logic reference;
		logic thermal;
		logic neg_b;
		logic neg_a;
		logic pos_b;
		logic pos_a;
		logic temperature;
		logic monitor1;
		logic monitor0;
		logic current1;
		logic current0;
	} alarm_in_t;

	// state of the selection block apart from the alarm synchroniser
	typedef struct packed {
		logic [15:0] conv_sel1;
		logic [15:0] pin_sel0;
		logic [15:0] pin_sel1;
		logic [3:0]  conv_en;
		logic [1:0]  pin_mode;
		logic        clamp;
		logic [1:0]  irq_status;
		logic [1:0]  irq_en;
		logic        conv_hit_d;
		logic        pin_hit_d;
		logic [3:0]  conv_pd;
		logic        pin_drive_off;
		logic        pin_tie_neg;
		logic        pin_tie_dac;
		logic        irq;
		logic        aw_have;
		logic        w_have;
		logic [11:0] aw_addr;
		logic [15:0] wdata;
		logic [1:0]  wstrb;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} main_state_t;

endpackage

// ---- core/level_sync.sv ----
`timescale 1ns/100ps
module level_sync #(
	parameter int W = 1
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_state_t;

	sync_state_t st_r;
	sync_state_t st_nxt;

	// first stage feeds only the second stage
	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = d;
		st_nxt.s2 = st_r.s1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q = st_r.s2;

endmodule // level_sync

// ---- core/apd_select.sv ----
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/100ps
// Functional notes
// [R01] bit 13 selects external alarm, converters
// [R02] bit 12 selects reference alarm, reset one
// [R03] bit 11 selects thermal alarm, reset one
// [R04] bits 5,4 select negative supplies, reset one
// [R05] bits 1,0 select positive supplies, reset one
// [R06] converter powers down only when channel enabled
// [R07] converter select-1 at 45h, reset 1833h
// [R08] pin select-0 bit 8 temperature, reset zero
// [R09] pin select-0 bits 5,4 monitor inputs
// [R10] pin select-0 bits 1,0 current monitors
// [R11] pin powers down only when pin enabled
// [R12] pin select-0 at 46h, reset 0000h
// [R13] pin select-1 at 47h, reset 1833h
// [R14] pin mode 00 ignore, 10 negative, 11 clamp; code clamps in 11 only with clamp bit 12 set, else ties negative
// [R15] disabled converter channel ignores events
// [R16] group event is OR of selected alarms
// [R17] reserved bits read zero, ignore writes
module apd_select
	import apd_select_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire alarm_in_t   alarm_in,
	output logic [3:0]       converter_pd,
	output logic             pin_drive_off,
	output logic             pin_tie_neg,
	output logic             pin_tie_dac,
	output logic             irq
);

	// ----------------------------------------------------------------
	// alarm synchronisation
	// ----------------------------------------------------------------
	main_state_t st_r;
	main_state_t st_nxt;
	alarm_in_t   al;
	logic [15:0] word0;
	logic [15:0] word1;
	logic        conv_hit;
	logic        pin_hit;
	logic [31:0] rd_data;
	logic        rd_ok;

	// alarms are asynchronous levels from the monitors
	level_sync #(
		.W (ALARM_W)
	) u_alarm_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       (alarm_in),
		.q       (al)
	);

	// lay synced alarms out like the select registers
	always_comb begin
		word0            = '0;
		word1            = '0;
		word0[TEMP_BIT]  = al.temperature;
		word0[MON1_BIT]  = al.monitor1;
		word0[MON0_BIT]  = al.monitor0;
		word0[CUR1_BIT]  = al.current1;
		word0[CUR0_BIT]  = al.current0;
		word1[EXT_BIT]   = al.ext_alarm;
		word1[REF_BIT]   = al.reference;
		word1[THERM_BIT] = al.thermal;
		word1[NEGB_BIT]  = al.neg_b;
		word1[NEGA_BIT]  = al.neg_a;
		word1[POSB_BIT]  = al.pos_b;
		word1[POSA_BIT]  = al.pos_a;
	end

	// group events: any selected alarm, ORed together
	assign conv_hit = |(word1 & st_r.conv_sel1);            // [R01] [R16]
	assign pin_hit  = |(word0 & st_r.pin_sel0)
			| |(word1 & st_r.pin_sel1);                    // [R16]

	// ----------------------------------------------------------------
	// register read decode
	// ----------------------------------------------------------------
	always_comb begin
		rd_data = '0;
		rd_ok   = 1'b1;
		unique case ({s_axi_araddr[11:2], 2'b00})
			ADDR_PD_ENABLE: begin
				rd_data[EN_LSB +: 4]   = st_r.conv_en;
				rd_data[MODE_LSB +: 2] = st_r.pin_mode;
				rd_data[CLAMP_BIT]     = st_r.clamp;
			end
			ADDR_CONV_SEL1:  rd_data[15:0] = st_r.conv_sel1;
			ADDR_PIN_SEL0:   rd_data[15:0] = st_r.pin_sel0;
			ADDR_PIN_SEL1:   rd_data[15:0] = st_r.pin_sel1;
			ADDR_IRQ_STATUS: begin
				rd_data[1:0]           = st_r.irq_status;
				rd_data[LIVE_LSB +: 2] = {st_r.pin_hit_d,
						st_r.conv_hit_d};
			end
			ADDR_IRQ_CLEAR:  rd_data = '0;
			ADDR_IRQ_ENABLE: rd_data[1:0] = st_r.irq_en;
			default:         rd_ok = 1'b0;
		endcase
	end

	// byte-lane merge; reserved bits forced low on every write
	function automatic logic [15:0] merge(
		input logic [15:0] old,
		input logic [15:0] data,
		input logic [1:0]  strb,
		input logic [15:0] mask
	);
		logic [15:0] v;
		v = old;
		if (strb[0]) begin
			v[7:0] = data[7:0];
		end
		if (strb[1]) begin
			v[15:8] = data[15:8];
		end
		return v & mask;
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic        do_write;
		logic [15:0] v;
		logic [1:0]  clr;
		logic        act;
		do_write = 1'b0;
		v        = '0;
		clr      = '0;
		act      = 1'b0;
		st_nxt   = st_r;

		// write address and data may arrive in either order
		if (s_axi_awvalid && st_r.awready) begin
			st_nxt.aw_have = 1'b1;
			st_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && st_r.wready) begin
			st_nxt.w_have = 1'b1;
			st_nxt.wdata  = s_axi_wdata[15:0];
			st_nxt.wstrb  = s_axi_wstrb[1:0];
		end
		if (s_axi_bready && st_r.bvalid) begin
			st_nxt.bvalid = 1'b0;
		end
		do_write = st_r.aw_have && st_r.w_have && !st_r.bvalid;

		if (do_write) begin
			st_nxt.aw_have = 1'b0;
			st_nxt.w_have  = 1'b0;
			st_nxt.bvalid  = 1'b1;
			st_nxt.bresp   = RESP_OKAY;
			unique case ({st_r.aw_addr[11:2], 2'b00})
				ADDR_PD_ENABLE: begin
					v = merge({3'b000, st_r.clamp, 2'b00,
							st_r.pin_mode, 4'h0, st_r.conv_en},
							st_r.wdata, st_r.wstrb, 16'hFFFF);
					st_nxt.conv_en  = v[EN_LSB +: 4];
					st_nxt.pin_mode = v[MODE_LSB +: 2];
					st_nxt.clamp    = v[CLAMP_BIT];
				end
				ADDR_CONV_SEL1: st_nxt.conv_sel1 = merge(
						st_r.conv_sel1, st_r.wdata,
						st_r.wstrb, MASK_SEL1);         // [R17]
				ADDR_PIN_SEL0: st_nxt.pin_sel0 = merge(
						st_r.pin_sel0, st_r.wdata,
						st_r.wstrb, MASK_SEL0);         // [R17]
				ADDR_PIN_SEL1: st_nxt.pin_sel1 = merge(
						st_r.pin_sel1, st_r.wdata,
						st_r.wstrb, MASK_SEL1);         // [R17]
				ADDR_IRQ_STATUS: ;
				ADDR_IRQ_CLEAR: begin
					if (st_r.wstrb[0]) begin
						clr = st_r.wdata[1:0];
					end
				end
				ADDR_IRQ_ENABLE: begin
					if (st_r.wstrb[0]) begin
						st_nxt.irq_en = st_r.wdata[1:0];
					end
				end
				default: st_nxt.bresp = RESP_SLVERR;
			endcase
		end
		// no new address or data while a write is pending
		st_nxt.awready = !st_nxt.aw_have && !st_nxt.bvalid;
		st_nxt.wready  = !st_nxt.w_have && !st_nxt.bvalid;

		// read: one outstanding, answered the cycle after acceptance
		if (s_axi_rready && st_r.rvalid) begin
			st_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && st_r.arready) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata  = rd_data;
			st_nxt.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
		st_nxt.arready = !st_nxt.rvalid;

		// converter outputs follow the event, per enabled channel
		st_nxt.conv_pd = conv_hit ? st_r.conv_en : 4'h0;  // [R06] [R15]

		// switched pin: mode 00 ignores, 1x acts on the event
		act = pin_hit && st_r.pin_mode[1];                // [R11] [R14]
		st_nxt.pin_drive_off = act;                        // [R14]
		st_nxt.pin_tie_neg   = act
				&& (!st_r.pin_mode[0] || !st_r.clamp);         // [R14]
		st_nxt.pin_tie_dac   = act
				&& st_r.pin_mode[0] && st_r.clamp;             // [R14]

		// sticky on rising event; a new event beats a clear
		st_nxt.conv_hit_d = conv_hit;
		st_nxt.pin_hit_d  = pin_hit;
		st_nxt.irq_status = (st_r.irq_status & ~clr)
				| {pin_hit && !st_r.pin_hit_d,
				conv_hit && !st_r.conv_hit_d};
		st_nxt.irq = |(st_nxt.irq_status & st_nxt.irq_en);
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r           <= '0;
			st_r.conv_sel1 <= RST_CONV_SEL1;              // [R02] [R03] [R07]
			st_r.pin_sel0  <= RST_PIN_SEL0;               // [R08] [R12]
			st_r.pin_sel1  <= RST_PIN_SEL1;               // [R13]
			st_r.conv_en   <= RST_CONV_EN;
			st_r.pin_mode  <= RST_PIN_MODE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs straight from the state register
	assign s_axi_awready = st_r.awready;
	assign s_axi_wready  = st_r.wready;
	assign s_axi_bvalid  = st_r.bvalid;
	assign s_axi_bresp   = st_r.bresp;
	assign s_axi_arready = st_r.arready;
	assign s_axi_rvalid  = st_r.rvalid;
	assign s_axi_rdata   = st_r.rdata;
	assign s_axi_rresp   = st_r.rresp;
	assign converter_pd  = st_r.conv_pd;
	assign pin_drive_off = st_r.pin_drive_off;
	assign pin_tie_neg   = st_r.pin_tie_neg;
	assign pin_tie_dac   = st_r.pin_tie_dac;
	assign irq           = st_r.irq;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// external or temperature alarm seen for three samples while selected and enabled
	sequence s_ext_armed;
		(alarm_in.ext_alarm && st_r.conv_sel1[EXT_BIT]
				&& st_r.conv_en[0]) [*3];
	endsequence

	sequence s_temp_armed;
		(alarm_in.temperature && st_r.pin_sel0[TEMP_BIT]
				&& st_r.pin_mode == 2'b10) [*3];
	endsequence

	AST_R01_EXT_TRIGGERS: assert property ( // R01
		@(posedge aclk) disable iff (!aresetn)
		s_ext_armed |=> converter_pd[0])
		else $error("selected external alarm did not power down");

	AST_R07_RESET_VALUES: assert property ( // R02 R03 R04 R05 R07
		@(posedge aclk)
		$rose(aresetn) |-> st_r.conv_sel1 == RST_CONV_SEL1)
		else $error("converter select-1 reset value wrong");

	AST_R12_RESET_VALUES: assert property ( // R08 R09 R10 R12 R13
		@(posedge aclk)
		$rose(aresetn) |-> (st_r.pin_sel0 == RST_PIN_SEL0)
				&& (st_r.pin_sel1 == RST_PIN_SEL1))
		else $error("pin select reset value wrong");

	AST_R06_CHANNEL_GATE: assert property ( // R06 R15
		@(posedge aclk) disable iff (!aresetn)
		converter_pd != 4'h0 |->
				(converter_pd & ~$past(st_r.conv_en)) == 4'h0)
		else $error("disabled converter channel powered down");

	AST_R16_CONV_CAUSE: assert property ( // R16
		@(posedge aclk) disable iff (!aresetn)
		converter_pd[0] |-> $past(|(word1 & st_r.conv_sel1)))
		else $error("converter power-down without selected alarm");

	AST_R08_TEMP_PATH: assert property ( // R08 R11
		@(posedge aclk) disable iff (!aresetn)
		s_temp_armed |=> pin_drive_off && pin_tie_neg)
		else $error("selected temperature alarm did not act on pin");

	AST_R14_MODE_IGNORE: assert property ( // R14
		@(posedge aclk) disable iff (!aresetn)
		st_r.pin_mode == 2'b00 |=> !pin_drive_off)
		else $error("pin acted while mode ignores events");

	AST_R14_CLAMP_DAC: assert property ( // R14
		@(posedge aclk) disable iff (!aresetn)
		pin_tie_dac |-> pin_drive_off && !pin_tie_neg
				&& $past(st_r.pin_mode == 2'b11 && st_r.clamp))
		else $error("pin tied to converter without clamp mode");

	AST_R11_PIN_CAUSE: assert property ( // R11 R16
		@(posedge aclk) disable iff (!aresetn)
		pin_drive_off |-> $past(pin_hit && st_r.pin_mode[1]))
		else $error("pin powered down without cause");

	AST_R17_RESERVED_ZERO: assert property ( // R17
		@(posedge aclk) disable iff (!aresetn)
		((st_r.conv_sel1 & ~MASK_SEL1) == 16'h0000)
		&& ((st_r.pin_sel0 & ~MASK_SEL0) == 16'h0000)
		&& ((st_r.pin_sel1 & ~MASK_SEL1) == 16'h0000))
		else $error("reserved select bit set");

endmodule // apd_select

// ---- tb/tb_apd_select.sv ----
`timescale 1ns/100ps
module tb_apd_select
	import apd_select_pkg::*;
;
	// ------------------------------------------------------------
	// bench signals
	// ------------------------------------------------------------
	logic        aclk;
	logic        aresetn;
	logic [11:0] awaddr;
	logic [11:0] araddr;
	logic        awvalid;
	logic        wvalid;
	logic        bready;
	logic        arvalid;
	logic        rready;
	logic [31:0] wdata;
	logic        awready;
	logic        wready;
	logic        bvalid;
	logic        arready;
	logic        rvalid;
	logic [1:0]  bresp;
	logic [1:0]  rresp;
	logic [31:0] rdata;
	logic [3:0]  converter_pd;
	logic        pin_drive_off;
	logic        pin_tie_neg;
	logic        pin_tie_dac;
	logic        irq;
	alarm_in_t   alm;
	int          err_count;
	int          cmp_count;

	apd_select dut (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awaddr  (awaddr),
		.s_axi_awvalid (awvalid),
		.s_axi_awready (awready),
		.s_axi_wdata   (wdata),
		.s_axi_wstrb   (4'hF),
		.s_axi_wvalid  (wvalid),
		.s_axi_wready  (wready),
		.s_axi_bresp   (bresp),
		.s_axi_bvalid  (bvalid),
		.s_axi_bready  (bready),
		.s_axi_araddr  (araddr),
		.s_axi_arvalid (arvalid),
		.s_axi_arready (arready),
		.s_axi_rdata   (rdata),
		.s_axi_rresp   (rresp),
		.s_axi_rvalid  (rvalid),
		.s_axi_rready  (rready),
		.alarm_in      (alm),
		.converter_pd  (converter_pd),
		.pin_drive_off (pin_drive_off),
		.pin_tie_neg   (pin_tie_neg),
		.pin_tie_dac   (pin_tie_dac),
		.irq           (irq)
	);

	// 100 ns clock
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	// ------------------------------------------------------------
	// shared helpers
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	// write: address and data offered together, each released once taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && awready) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!bvalid);
		chk("bresp", {30'h0, er}, {30'h0, bresp});
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e,
		input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		chk("rdata", e, rdata);
		chk("rresp", {30'h0, er}, {30'h0, rresp});
		rready <= 1'b0;
	endtask

	// outputs need sync plus register stages, so five edges are ample
	task automatic settle();
		repeat (5) @(posedge aclk);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset_vals();
		rd(ADDR_CONV_SEL1, 32'h0000_1833, RESP_OKAY);
		rd(ADDR_PIN_SEL0, 32'h0000_0000, RESP_OKAY);
		rd(ADDR_PIN_SEL1, 32'h0000_1833, RESP_OKAY);
		rd(ADDR_PD_ENABLE, 32'h0000_020F, RESP_OKAY);
	endtask

	// reserved positions must stay zero after an all-ones write
	task automatic t_reserved();
		wr(ADDR_CONV_SEL1, 32'hFFFF_FFFF, RESP_OKAY);
		wr(ADDR_PIN_SEL0, 32'hFFFF_FFFF, RESP_OKAY);
		wr(ADDR_PIN_SEL1, 32'hFFFF_FFFF, RESP_OKAY);
		rd(ADDR_CONV_SEL1, 32'h0000_3833, RESP_OKAY);
		rd(ADDR_PIN_SEL0, 32'h0000_0133, RESP_OKAY);
		rd(ADDR_PIN_SEL1, 32'h0000_3833, RESP_OKAY);
		wr(12'h3FC, 32'hFFFF_FFFF, RESP_SLVERR);
		rd(12'h3FC, 32'h0000_0000, RESP_SLVERR);
	endtask

	// reference alarm feeds both groups with the selects left set
	task automatic t_irq();
		wr(ADDR_IRQ_ENABLE, 32'h0000_0001, RESP_OKAY);
		rd(ADDR_IRQ_ENABLE, 32'h0000_0001, RESP_OKAY);
		alm <= alarm_in_t'(12'h400);
		settle();
		chk("irq", 32'h1, {31'h0, irq});
		rd(ADDR_IRQ_STATUS, 32'h0000_0033, RESP_OKAY);
		alm <= '0;
		settle();
		rd(ADDR_IRQ_STATUS, 32'h0000_0003, RESP_OKAY);
		chk("irq", 32'h1, {31'h0, irq});
		wr(ADDR_IRQ_ENABLE, 32'h0000_0000, RESP_OKAY);
		settle();
		chk("irq", 32'h0, {31'h0, irq});
		wr(ADDR_IRQ_ENABLE, 32'h0000_0002, RESP_OKAY);
		settle();
		chk("irq", 32'h1, {31'h0, irq});
		wr(ADDR_IRQ_STATUS, 32'h0000_FFFF, RESP_OKAY);
		rd(ADDR_IRQ_STATUS, 32'h0000_0003, RESP_OKAY);
		wr(ADDR_IRQ_CLEAR, 32'h0000_0003, RESP_OKAY);
		settle();
		rd(ADDR_IRQ_STATUS, 32'h0000_0000, RESP_OKAY);
		rd(ADDR_IRQ_CLEAR, 32'h0000_0000, RESP_OKAY);
		chk("irq", 32'h0, {31'h0, irq});
	endtask

	// one select bit on, its alarm high, then the bit off again
	task automatic sel_case(input logic [11:0] a, input int b,
		input int ai, input logic [4:0] e);
		wr(a, 32'h1 << b, RESP_OKAY);
		alm <= alarm_in_t'(12'h001 << ai);
		settle();
		chk("pd_on", {27'h0, e}, {27'h0, converter_pd, pin_drive_off});
		wr(a, 32'h0, RESP_OKAY);
		settle();
		chk("pd_off", 32'h0, {27'h0, converter_pd, pin_drive_off});
		alm <= '0;
		settle();
	endtask

	task automatic t_select();
		int sb[12];
		int ai[12];
		sb = '{13, 12, 11, 5, 4, 1, 0, 8, 5, 4, 1, 0};
		ai = '{11, 10, 9, 8, 7, 6, 5, 4, 3, 2, 1, 0};
		wr(ADDR_CONV_SEL1, 32'h0, RESP_OKAY);
		wr(ADDR_PIN_SEL0, 32'h0, RESP_OKAY);
		wr(ADDR_PIN_SEL1, 32'h0, RESP_OKAY);
		for (int i = 0; i < 7; i++) begin
			sel_case(ADDR_CONV_SEL1, sb[i], ai[i], 5'h1E);
			sel_case(ADDR_PIN_SEL1, sb[i], ai[i], 5'h01);
		end
		for (int i = 7; i < 12; i++) begin
			sel_case(ADDR_PIN_SEL0, sb[i], ai[i], 5'h01);
		end
	endtask

	// channel enables and pin modes gate a standing reference alarm
	task automatic t_enable();
		logic [15:0] ev[5];
		logic [6:0]  ex[5];
		ev = '{16'h0205, 16'h0000, 16'h0300, 16'h130F, 16'h010F};
		ex = '{7'h2E, 7'h00, 7'h06, 7'h7D, 7'h78};
		wr(ADDR_CONV_SEL1, 32'h0000_1000, RESP_OKAY);
		wr(ADDR_PIN_SEL1, 32'h0000_1000, RESP_OKAY);
		alm <= alarm_in_t'(12'h400);
		for (int i = 0; i < 5; i++) begin
			wr(ADDR_PD_ENABLE, {16'h0, ev[i]}, RESP_OKAY);
			settle();
			chk("pd_gate", {25'h0, ex[i]}, {25'h0, converter_pd,
				pin_drive_off, pin_tie_neg, pin_tie_dac});
		end
		alm <= '0;
	endtask

	// ------------------------------------------------------------
	// verdict and run control
	// ------------------------------------------------------------
	task automatic end_of_test();
		if (err_count == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// whole run needs under a thousand cycles; this limit only cuts a hang
	initial begin
		repeat (20000) @(posedge aclk);
		err_count++;
		end_of_test();
	end

	// main sequence
	initial begin
		err_count = 0;
		cmp_count = 0;
		aresetn = 1'b0;
		awaddr = 12'h0;
		araddr = 12'h0;
		wdata = 32'h0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		alm = '0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset_vals();
		t_reserved();
		t_irq();
		t_select();
		t_enable();
		end_of_test();
	end

endmodule // tb_apd_select
